// *** pkg/ftbs_if.sv ***
interface ftbs_if;
    logic [ftbs_pkg::ADDR_W-1:0] addr;
    logic chip_select_low;
    logic chip_select_high;
    logic chip_select_two_low;
    logic proc_addr_strobe_low;
    logic ctrl_addr_strobe_low;
    logic burst_advance_low;
    logic global_write_low;
    logic byte_write_gate_low;
    logic [3:0] lane_write_low;
    logic output_enable_low;
    logic sleep_request;
    logic [ftbs_pkg::DQ_W-1:0] dq_ctrl;
    logic dq_ctrl_oe;
    logic [ftbs_pkg::DQ_W-1:0] dq_sram;
    logic dq_sram_oe;
    logic [ftbs_pkg::DQ_W-1:0] dq;

    // Resolved level of the shared data bus; an undriven bus reads as zero.
    assign dq = dq_sram_oe ? dq_sram : (dq_ctrl_oe ? dq_ctrl : '0);

    modport sram (
        input addr, chip_select_low, chip_select_high, chip_select_two_low,
        input proc_addr_strobe_low, ctrl_addr_strobe_low, burst_advance_low,
        input global_write_low, byte_write_gate_low, lane_write_low,
        input output_enable_low, sleep_request, dq,
        output dq_sram, dq_sram_oe
    );

    modport ctrl (
        output addr, chip_select_low, chip_select_high, chip_select_two_low,
        output proc_addr_strobe_low, ctrl_addr_strobe_low, burst_advance_low,
        output global_write_low, byte_write_gate_low, lane_write_low,
        output output_enable_low, sleep_request, dq_ctrl, dq_ctrl_oe,
        input dq
    );
endinterface

// *** pkg/ftbs_pkg.sv ***
package ftbs_pkg;

    // Bus organisation.
    localparam int ADDR_W = 16;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int LANE_W = 9;
    localparam int DQ_W = 36;
    localparam int PAR_POS = 8;

    // Burst counter.
    localparam logic [1:0] CNT_RST = 2'h0;
    localparam logic [1:0] CNT_STEP = 2'h1;

    // Reset values of the bus controls, all inactive.
    localparam logic STROBE_RST = 1'b1;
    localparam logic [3:0] LANE_WE_RST = 4'hF;

    // Cycle the memory performed at the last edge.
    typedef enum logic [2:0] {
        FTBS_CYC_IDLE = 3'h0,
        FTBS_CYC_DESEL = 3'h1,
        FTBS_CYC_SLEEP = 3'h2,
        FTBS_CYC_BEGIN = 3'h3,
        FTBS_CYC_CONT = 3'h4,
        FTBS_CYC_SUSP = 3'h5
    } ftbs_cycle_t;

    // Controller states.
    typedef enum logic [1:0] {
        FTBS_ST_IDLE = 2'h0,
        FTBS_ST_READ = 2'h1,
        FTBS_ST_WRITE = 2'h2
    } ftbs_state_t;

endpackage

// *** verification/ftbs_chk.sv ***
module ftbs_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Watched bus
    input wire logic chip_select_low,
    input wire logic chip_select_high,
    input wire logic chip_select_two_low,
    input wire logic proc_addr_strobe_low,
    input wire logic ctrl_addr_strobe_low,
    input wire logic burst_advance_low,
    input wire logic global_write_low,
    input wire logic byte_write_gate_low,
    input wire logic [3:0] lane_write_low,
    input wire logic output_enable_low,
    input wire logic sleep_request,
    input wire logic [ftbs_pkg::DQ_W-1:0] dq_sram,
    input wire logic dq_sram_oe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    wire logic wr = !global_write_low || (!byte_write_gate_low && (lane_write_low != 4'hF));
    wire logic sel = !chip_select_low && chip_select_high && !chip_select_two_low;
    wire logic awake = !sleep_request;
    wire logic off_ok = output_enable_low || sleep_request;

    // One edge with both strobes high, the given advance level and write indication.
    sequence s_step(bit adv, bit w);
        awake && proc_addr_strobe_low && ctrl_addr_strobe_low && (burst_advance_low == adv) && (wr == w);
    endsequence

    property p_power_up;
        $fell(reset_i) |-> !dq_sram_oe;
    endproperty
    property p_oe_gate;
        output_enable_low |-> !dq_sram_oe;
    endproperty
    property p_sleep_off;
        sleep_request |-> !dq_sram_oe;
    endproperty
    property p_proc_read;
        awake && !proc_addr_strobe_low && sel |=> off_ok || dq_sram_oe;
    endproperty
    property p_ctrl_write;
        awake && proc_addr_strobe_low && !ctrl_addr_strobe_low && sel && wr |=> !dq_sram_oe;
    endproperty
    property p_desel;
        awake && !ctrl_addr_strobe_low && chip_select_low |=> !dq_sram_oe;
    endproperty
    property p_cont_read;
        s_step(1'b0, 1'b0) |=> off_ok || dq_sram_oe;
    endproperty
    property p_cont_write;
        s_step(1'b0, 1'b1) |=> !dq_sram_oe;
    endproperty
    property p_susp_reread;
        s_step(1'b1, 1'b0) ##1 s_step(1'b1, 1'b0) |=> $stable(dq_sram);
    endproperty
    property p_susp_write;
        s_step(1'b1, 1'b1) |=> !dq_sram_oe;
    endproperty

    a_power_up: assert property (p_power_up) else $error("bus driven after power-up");
    a_oe_gate: assert property (p_oe_gate) else $error("bus driven with output enable high");
    a_sleep_off: assert property (p_sleep_off) else $error("bus driven while asleep");
    a_proc_read: assert property (p_proc_read) else $error("processor start did not read");
    a_ctrl_write: assert property (p_ctrl_write) else $error("controller write start drove bus");
    a_desel: assert property (p_desel) else $error("deselect drove bus");
    a_cont_read: assert property (p_cont_read) else $error("continue read did not drive");
    a_cont_write: assert property (p_cont_write) else $error("continue write drove bus");
    a_susp_reread: assert property (p_susp_reread) else $error("suspend read changed data");
    a_susp_write: assert property (p_susp_write) else $error("suspend write drove bus");
endmodule

// *** verification/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic burst_order_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic cmd_ready_o;
    logic cmd_write_i = 1'b0;
    logic [15:0] cmd_addr_i = 16'h0000;
    logic [1:0] cmd_beats_i = 2'h0;
    logic [3:0] cmd_lanes_i = 4'h0;
    logic [ftbs_pkg::DQ_W-1:0] cmd_data_i = 36'h0;
    logic wdata_valid_i = 1'b0;
    logic wdata_ready_o;
    logic [ftbs_pkg::DQ_W-1:0] wdata_i = 36'h0;
    logic rdata_valid_o;
    logic [ftbs_pkg::DQ_W-1:0] rdata_o;
    logic sleep_i = 1'b0;
    ftbs_pkg::ftbs_cycle_t cycle_o;
    logic sleeping_o;
    logic [ftbs_pkg::DQ_W-1:0] ref_mem [0:7];
    logic [ftbs_pkg::DQ_W-1:0] beat [0:3];
    int bad_count = 0;
    int compares = 0;

    always #10 clk_i = ~clk_i;

    ftbs_if bus_if();
    ftbs_sram ftbs_sram_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if), .burst_order_i(burst_order_i),
        .cycle_o(cycle_o), .sleeping_o(sleeping_o));
    ftbs_ctrl ftbs_ctrl_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_beats_i(cmd_beats_i),
        .cmd_lanes_i(cmd_lanes_i), .cmd_data_i(cmd_data_i), .wdata_valid_i(wdata_valid_i),
        .wdata_ready_o(wdata_ready_o), .wdata_i(wdata_i), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
        .sleep_i(sleep_i));
    ftbs_chk ftbs_chk_inst (.clk_i(clk_i), .reset_i(reset_i), .chip_select_low(bus_if.chip_select_low),
        .chip_select_high(bus_if.chip_select_high), .chip_select_two_low(bus_if.chip_select_two_low),
        .proc_addr_strobe_low(bus_if.proc_addr_strobe_low), .ctrl_addr_strobe_low(bus_if.ctrl_addr_strobe_low),
        .burst_advance_low(bus_if.burst_advance_low), .global_write_low(bus_if.global_write_low),
        .byte_write_gate_low(bus_if.byte_write_gate_low), .lane_write_low(bus_if.lane_write_low),
        .output_enable_low(bus_if.output_enable_low), .sleep_request(bus_if.sleep_request),
        .dq_sram(bus_if.dq_sram), .dq_sram_oe(bus_if.dq_sram_oe));

    task automatic wrap_up();
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits at falling edges for a settled high ready, giving up after a fixed count.
    task automatic wait_high(input bit on_wdata);
        int n;
        n = 0;
        @(negedge clk_i);
        while ((on_wdata ? wdata_ready_o : cmd_ready_o) !== 1'b1) begin
            n++;
            if (n > 40) begin
                bad_count++;
                wrap_up();
            end
            @(negedge clk_i);
        end
    endtask

    function automatic logic [2:0] beat_idx(input logic [15:0] a, input logic [1:0] k);
        beat_idx = {a[2], burst_order_i ? (a[1:0] ^ k) : (a[1:0] + k)};
    endfunction

    task automatic set_beats(input int s);
        for (int k = 0; k < 4; k++) begin
            beat[k] = {9'h1C0 + 9'(s + k), 9'h0B0 + 9'(s + k), 9'h0A0 + 9'(s + k), 9'h150 + 9'(s + k)};
        end
    endtask

    task automatic issue(input logic wr, input logic [15:0] a, input logic [1:0] nb, input logic [3:0] ln);
        wait_high(1'b0);
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_write_i <= wr;
        cmd_addr_i <= a;
        cmd_beats_i <= nb;
        cmd_lanes_i <= ln;
        cmd_data_i <= beat[0];
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
    endtask

    task automatic write_burst(input logic [15:0] a, input logic [1:0] nb, input logic [3:0] ln, input int stall);
        for (int k = 0; k <= nb; k++) begin
            for (int i = 0; i < 4; i++) begin
                if (ln[i]) begin
                    ref_mem[beat_idx(a, 2'(k))][9*i+:9] = beat[k][9*i+:9];
                end
            end
        end
        issue(1'b1, a, nb, ln);
        for (int k = 1; k <= nb; k++) begin
            if (stall > 0) begin
                wdata_valid_i <= 1'b0;
                repeat (stall) @(posedge clk_i);
            end
            wdata_valid_i <= 1'b1;
            wdata_i <= beat[k];
            wait_high(1'b1);
            @(posedge clk_i);
        end
        wdata_valid_i <= 1'b0;
    endtask

    task automatic read_burst(input logic [15:0] a, input logic [1:0] nb);
        int k;
        int n;
        k = 0;
        n = 0;
        issue(1'b0, a, nb, 4'h0);
        while (k <= nb && n < 40) begin
            @(negedge clk_i);
            n++;
            if (rdata_valid_o === 1'b1) begin
                check("rdata_o", ref_mem[beat_idx(a, 2'(k))], rdata_o);
                k++;
            end
        end
        if (k <= nb) begin
            bad_count++;
            wrap_up();
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        check("dq_sram_oe", 1'b0, bus_if.dq_sram_oe);
        @(posedge clk_i);
        reset_i <= 1'b0;
        set_beats(16);
        write_burst(16'h0000, 2'h3, 4'hF, 0);
        set_beats(48);
        write_burst(16'h0005, 2'h3, 4'hF, 3);
        read_burst(16'h0006, 2'h3);
        @(posedge clk_i);
        burst_order_i <= 1'b0;
        read_burst(16'h0005, 2'h3);
        set_beats(80);
        write_burst(16'h0003, 2'h1, 4'h5, 0);
        read_burst(16'h0000, 2'h3);
        @(posedge clk_i);
        sleep_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        check("sleeping_o", 1'b1, sleeping_o);
        check("dq_sram_oe", 1'b0, bus_if.dq_sram_oe);
        check("cycle_o", ftbs_pkg::FTBS_CYC_SLEEP, cycle_o);
        @(posedge clk_i);
        sleep_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        read_burst(16'h0007, 2'h2);
        @(negedge clk_i);
        check("cycle_o", ftbs_pkg::FTBS_CYC_DESEL, cycle_o);
        wrap_up();
    end
endmodule

// *** verilog/ftbs_ctrl.sv ***
module ftbs_ctrl #(
    parameter int ADDR_W = ftbs_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Memory bus
    ftbs_if.ctrl bus,
    // Command
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic [1:0] cmd_beats_i,
    input wire logic [3:0] cmd_lanes_i,
    input wire logic [ftbs_pkg::DQ_W-1:0] cmd_data_i,
    // Further write beats
    input wire logic wdata_valid_i,
    output logic wdata_ready_o,
    input wire logic [ftbs_pkg::DQ_W-1:0] wdata_i,
    // Read data
    output logic rdata_valid_o,
    output logic [ftbs_pkg::DQ_W-1:0] rdata_o,
    // Low power request
    input wire logic sleep_i
);

    ftbs_pkg::ftbs_state_t state;
    logic [1:0] left;
    logic [3:0] lanes;
    logic read_beat;
    logic capture;
    logic proc_lead;
    logic [ADDR_W-1:0] addr;
    logic ce_low;
    logic proc_addr_strobe_low_low;
    logic ctrl_addr_strobe_low_low;
    logic adv_low;
    logic gw_low;
    logic bwe_low;
    logic [3:0] bw_low;
    logic oe_low;
    logic sleep;
    logic [ftbs_pkg::DQ_W-1:0] dq_out;
    logic dq_oe;

    wire logic accept;
    wire logic take;

    assign accept = cmd_valid_i & cmd_ready_o & (state == ftbs_pkg::FTBS_ST_IDLE);
    assign take = wdata_valid_i & wdata_ready_o;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ftbs_pkg::FTBS_ST_IDLE;
            left <= '0;
            lanes <= '0;
            read_beat <= 1'b0;
            capture <= 1'b0;
            proc_lead <= 1'b0;
            addr <= '0;
            ce_low <= ftbs_pkg::STROBE_RST;
            proc_addr_strobe_low_low <= ftbs_pkg::STROBE_RST;
            ctrl_addr_strobe_low_low <= ftbs_pkg::STROBE_RST;
            adv_low <= ftbs_pkg::STROBE_RST;
            gw_low <= ftbs_pkg::STROBE_RST;
            bwe_low <= ftbs_pkg::STROBE_RST;
            bw_low <= ftbs_pkg::LANE_WE_RST;
            oe_low <= ftbs_pkg::STROBE_RST;
            sleep <= 1'b0;
            dq_out <= '0;
            dq_oe <= 1'b0;
            cmd_ready_o <= 1'b1;
            wdata_ready_o <= 1'b0;
            rdata_valid_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            sleep <= sleep_i;
            capture <= read_beat;
            rdata_valid_o <= capture;
            if (capture) begin
                rdata_o <= bus.dq;
            end
            // Output enable stays low until the last read beat is captured.
            oe_low <= ~read_beat;
            read_beat <= 1'b0;
            proc_addr_strobe_low_low <= 1'b1;
            ctrl_addr_strobe_low_low <= 1'b1;
            adv_low <= 1'b1;
            gw_low <= 1'b1;
            bwe_low <= 1'b1;
            bw_low <= ftbs_pkg::LANE_WE_RST;
            dq_oe <= 1'b0;
            case (state)
                ftbs_pkg::FTBS_ST_IDLE: begin
                    ce_low <= 1'b1;
                    ctrl_addr_strobe_low_low <= 1'b0;
                    if (accept) begin
                        ce_low <= 1'b0;
                        addr <= cmd_addr_i;
                        left <= cmd_beats_i;
                        lanes <= cmd_lanes_i;
                        cmd_ready_o <= 1'b0;
                        if (cmd_write_i) begin
                            oe_low <= 1'b1;
                            dq_out <= cmd_data_i;
                            state <= ftbs_pkg::FTBS_ST_WRITE;
                            if (&cmd_lanes_i) begin
                                // Full words start with the controller strobe, data on the same edge.
                                gw_low <= ~(&cmd_lanes_i);
                                bwe_low <= 1'b0;
                                bw_low <= ~cmd_lanes_i;
                                dq_oe <= 1'b1;
                                wdata_ready_o <= (cmd_beats_i != 2'h0);
                            end else begin
                                // Partial words start as a processor-strobe read and are written next edge.
                                ctrl_addr_strobe_low_low <= 1'b1;
                                proc_addr_strobe_low_low <= 1'b0;
                                proc_lead <= 1'b1;
                            end
                        end else begin
                            ctrl_addr_strobe_low_low <= 1'b1;
                            proc_addr_strobe_low_low <= 1'b0;
                            oe_low <= 1'b0;
                            read_beat <= 1'b1;
                            state <= ftbs_pkg::FTBS_ST_READ;
                        end
                    end
                end
                ftbs_pkg::FTBS_ST_READ: begin
                    if (left != 2'h0) begin
                        adv_low <= 1'b0;
                        oe_low <= 1'b0;
                        read_beat <= 1'b1;
                        left <= left - 2'h1;
                    end else begin
                        cmd_ready_o <= 1'b1;
                        state <= ftbs_pkg::FTBS_ST_IDLE;
                    end
                end
                ftbs_pkg::FTBS_ST_WRITE: begin
                    oe_low <= 1'b1;
                    if (proc_lead) begin
                        // The first beat goes to the current address with advance held off.
                        gw_low <= ~(&lanes);
                        bwe_low <= 1'b0;
                        bw_low <= ~lanes;
                        dq_oe <= 1'b1;
                        proc_lead <= 1'b0;
                        wdata_ready_o <= (left != 2'h0);
                    end else if (left == 2'h0) begin
                        cmd_ready_o <= 1'b1;
                        state <= ftbs_pkg::FTBS_ST_IDLE;
                    end else if (take) begin
                        adv_low <= 1'b0;
                        gw_low <= ~(&lanes);
                        bwe_low <= 1'b0;
                        bw_low <= ~lanes;
                        dq_out <= wdata_i;
                        dq_oe <= 1'b1;
                        left <= left - 2'h1;
                        wdata_ready_o <= (left != 2'h1);
                    end
                    // Without data the burst stays suspended as a wait state.
                end
                default: begin
                    state <= ftbs_pkg::FTBS_ST_IDLE;
                end
            endcase
        end
    end

    assign bus.addr = addr;
    assign bus.chip_select_low = ce_low;
    assign bus.chip_select_high = 1'b1;
    assign bus.chip_select_two_low = 1'b0;
    assign bus.proc_addr_strobe_low = proc_addr_strobe_low_low;
    assign bus.ctrl_addr_strobe_low = ctrl_addr_strobe_low_low;
    assign bus.burst_advance_low = adv_low;
    assign bus.global_write_low = gw_low;
    assign bus.byte_write_gate_low = bwe_low;
    assign bus.lane_write_low = bw_low;
    assign bus.output_enable_low = oe_low;
    assign bus.sleep_request = sleep;
    assign bus.dq_ctrl = dq_out;
    assign bus.dq_ctrl_oe = dq_oe;

endmodule

// *** verilog/ftbs_sram.sv ***
//
// Behaviour
// - Sync inputs on rising edge; OE, sleep asynchronous.
// - Write when global or gated lane enables.
// - Lane enable writes its byte and parity.
// - Parity lanes exist per organisation only.
// - Processor strobe selected begins burst, always read.
// - Controller strobe begins burst; deselect if unselected.
// - Processor strobe with chip select low but unselected gives deselect, drive off.
// - Advance low without strobes reads next address.
// - Advance with write writes next address.
// - Advance high without strobes rereads current address.
// - Suspend with write writes current address.
// - Controller inserts waits by suspending burst.
// - Controller holds OE high around write data.
// - Write after processor start uses next edge.
// - Data outputs off during power-up.
// - Order high interleaves low address bits.
// - Order low increments, wrapping in four.
// - Gated writes take any lane combination.
//
module ftbs_sram #(
    parameter int ADDR_W = ftbs_pkg::ADDR_W,
    parameter int LANES = ftbs_pkg::LANES,
    parameter bit PARITY = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Memory bus
    ftbs_if.sram bus,
    // Burst order strap, high for interleaved
    input wire logic burst_order_i,
    // Status
    output ftbs_pkg::ftbs_cycle_t cycle_o,
    output logic sleeping_o
);

    localparam int DEPTH = 1 << ADDR_W;
    localparam int W = ftbs_pkg::DQ_W;

    // Low two address bits of a burst beat.
    function automatic logic [1:0] burst_low(input logic [1:0] first, input logic [1:0] cnt,
                                             input logic order);
        if (order) begin
            burst_low = first ^ cnt;
        end else begin
            burst_low = first + cnt;
        end
    endfunction

    // Lane write enables, limited to the lanes this organisation has.
    function automatic logic [3:0] lane_enables(input logic gw_low, input logic gate_low,
                                                input logic [3:0] bw_low);
        logic [3:0] en;
        logic [3:0] present;
        en = {4{~gw_low}} | ({4{~gate_low}} & ~bw_low);
        present = (LANES == 4) ? 4'hF : 4'h3;
        lane_enables = en & present;
    endfunction

    // Bit mask of the data and parity bits covered by the enabled lanes.
    function automatic logic [W-1:0] lane_mask(input logic [3:0] en);
        logic [W-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            for (int b = 0; b < ftbs_pkg::BYTE_W; b++) begin
                m[i*ftbs_pkg::LANE_W+b] = en[i];
            end
            m[i*ftbs_pkg::LANE_W+ftbs_pkg::PAR_POS] = en[i] & PARITY;
        end
        lane_mask = m;
    endfunction

    logic [W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] base;
    logic [1:0] cnt;
    logic drive;
    logic [W-1:0] dq_out;
    ftbs_pkg::ftbs_cycle_t cycle;
    logic sleeping;

    // Cycle decode of the inputs sampled at this edge.
    wire logic selected;
    wire logic proc_start;
    wire logic ctrl_start;
    wire logic carry_on;
    wire logic [3:0] lane_we;
    wire logic any_we;
    wire logic awake;
    wire logic begin_burst;
    wire logic deselect;
    wire logic do_write;
    wire logic do_read;
    wire logic [1:0] next_cnt;
    wire logic [ADDR_W-1:0] next_base;
    wire logic [ADDR_W-1:0] cur_addr;
    wire logic [W-1:0] wmask;
    wire logic [W-1:0] next_word;
    wire logic next_drive;
    wire ftbs_pkg::ftbs_cycle_t next_cycle;

    assign awake = ~bus.sleep_request;
    assign selected = ~bus.chip_select_low & bus.chip_select_high & ~bus.chip_select_two_low;
    assign proc_start = ~bus.proc_addr_strobe_low & ~bus.chip_select_low;
    assign ctrl_start = ~proc_start & ~bus.ctrl_addr_strobe_low;
    assign carry_on = ~proc_start & bus.ctrl_addr_strobe_low;
    assign lane_we = lane_enables(bus.global_write_low, bus.byte_write_gate_low, bus.lane_write_low);
    assign any_we = |lane_we;
    assign begin_burst = awake & (proc_start | ctrl_start) & selected;
    assign deselect = awake & (proc_start | ctrl_start) & ~selected;
    assign do_write = awake & any_we & ((ctrl_start & selected) | carry_on);
    assign do_read = (begin_burst | (awake & carry_on)) & ~do_write;

    assign next_base = begin_burst ? bus.addr : base;
    assign next_cnt = begin_burst ? ftbs_pkg::CNT_RST :
                      (awake & carry_on & ~bus.burst_advance_low) ? cnt + ftbs_pkg::CNT_STEP :
                      cnt;
    assign cur_addr = {next_base[ADDR_W-1:2], burst_low(next_base[1:0], next_cnt, burst_order_i)};
    assign wmask = lane_mask(lane_we);
    assign next_word = (mem[cur_addr] & ~wmask) | (bus.dq & wmask);
    assign next_drive = do_read;

    assign next_cycle = ~awake ? ftbs_pkg::FTBS_CYC_SLEEP :
                        deselect ? ftbs_pkg::FTBS_CYC_DESEL :
                        begin_burst ? ftbs_pkg::FTBS_CYC_BEGIN :
                        ~bus.burst_advance_low ? ftbs_pkg::FTBS_CYC_CONT :
                        ftbs_pkg::FTBS_CYC_SUSP;

    // Control state; the drive flag starts low so the bus stays released.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            base <= '0;
            cnt <= ftbs_pkg::CNT_RST;
            drive <= 1'b0;
            cycle <= ftbs_pkg::FTBS_CYC_IDLE;
            sleeping <= 1'b0;
        end else begin
            base <= next_base;
            cnt <= next_cnt;
            drive <= next_drive;
            cycle <= next_cycle;
            sleeping <= ~awake;
        end
    end

    // Storage array and flow-through read register.
    always_ff @(posedge clk_i) begin
        if (do_write) begin
            mem[cur_addr] <= next_word;
        end
        dq_out <= mem[cur_addr] & lane_mask(4'hF);
    end

    // Read data reaches the bus only while output enable is low and not asleep.
    assign bus.dq_sram = dq_out;
    assign bus.dq_sram_oe = drive & ~bus.output_enable_low & ~bus.sleep_request;

    assign cycle_o = cycle;
    assign sleeping_o = sleeping;

endmodule
